// file: common/dcs_pkg.sv
/*
 display clock synthesizer control: shared constants for both ends.
 assumes one clock (pclk, 100 MHz) and asynchronous active-low reset.
*/
package dcs_pkg;
   // -----------------------------------------------------------------
   // sideband address layout
   // -----------------------------------------------------------------
   localparam int unsigned TGT_W    = 8;
   localparam int unsigned START_W  = 8;
   localparam int unsigned SB_AW    = TGT_W + START_W;
   localparam logic [7:0]  TGT_SPREAD    = 8'h02;
   localparam logic [7:0]  TGT_NONSPREAD = 8'h05;
   localparam logic [7:0]  TGT_PIXEL     = 8'h06;
   // -----------------------------------------------------------------
   // synthesizer register starts
   // -----------------------------------------------------------------
   localparam logic [7:0]  OFS_INT_PHASE_DIV = 8'h00;
   localparam logic [7:0]  OFS_FRAC_DITHER   = 8'h04;
   localparam logic [7:0]  OFS_MOD_CTRL      = 8'h0c;
   localparam logic [7:0]  OFS_HALF_DIV      = 8'h10;
   // field positions
   localparam int unsigned BIT_PROPAGATE  = 0;
   localparam int unsigned DIV_LSB        = 1;
   localparam int unsigned DIV_W          = 7;
   localparam int unsigned PHASE_LSB      = 8;
   localparam int unsigned PHASE_W        = 7;
   localparam int unsigned BIT_DITHER_EN  = 0;
   localparam int unsigned FRAC_LSB       = 1;
   localparam int unsigned FRAC_W         = 31;
   localparam int unsigned BIT_POWER_DN_N = 0;
   localparam int unsigned BIT_PATT_HALT  = 3;
   localparam int unsigned BIT_DIV_ONLY   = 8;
   localparam int unsigned BIT_HALVE      = 4;
   // reset values and minimum divider code
   localparam logic [6:0]  DIV_RESET      = 7'h12;
   localparam logic [6:0]  DIV_MIN_CODE   = 7'h03;
   localparam logic [6:0]  PHASE_RESET    = 7'h00;
   localparam logic [30:0] FRAC_RESET     = 31'h0;
   // software wait counts in pclk cycles at 100 MHz
   localparam int unsigned WARMUP_CYCLES  = 2400;   // 24 us power-on warm-up
   localparam int unsigned NEUTRAL_CYCLES = 3200;   // 32 us pattern to neutral
   // clock 1 and 5 start powered down, clock 4 starts enabled
   localparam logic [2:0]  PDN_RESET      = 3'b101;
   // -----------------------------------------------------------------
   // controller apb registers (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0]  APB_SB_ADDR    = 8'h00;
   localparam logic [7:0]  APB_SB_DATA    = 8'h04;
   localparam logic [7:0]  APB_SB_CTLSTAT = 8'h08;
   localparam logic [7:0]  APB_PIX_GATE   = 8'h0c;
   localparam int unsigned BIT_CS_BUSY    = 0;
   localparam int unsigned BIT_CS_WRITE   = 1;
   localparam int unsigned BIT_CS_ERR     = 2;
   // sideband opcodes
   typedef enum logic {DCS_OP_READ, DCS_OP_WRITE} dcs_op_t;
endpackage

// file: common/dcs_sb_if.sv
/*
 sideband link between the controller and the synthesizer registers.
 assumes both ends on pclk; request held until ack.
*/
`timescale 1ns/100ps
`default_nettype none
interface dcs_sb_if;
   import dcs_pkg::*;
   logic             req;     // request level, held until ack
   dcs_op_t          op;
   logic [SB_AW-1:0] addr;    // target in upper byte, start in lower
   logic [31:0]      wdata;
   logic             ack;     // one-cycle pulse
   logic [31:0]      rdata;
   logic             err;     // with ack: no such target/register
   modport master (output req, output op, output addr, output wdata,
                   input ack, input rdata, input err);
   modport target (input req, input op, input addr, input wdata,
                   output ack, output rdata, output err);
endinterface
`default_nettype wire

// file: design/dcs_sb_master.sv
/*
 apb-programmed sideband master: address, data and control/status
 registers, plus the pixel clock gate.
 assumes apb3 master on pclk and the synthesizer on the sideband.
*/
`timescale 1ns/100ps
`default_nettype none
module dcs_sb_master
   import dcs_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pixel clock gate out (1 = ungated)
   output logic             pix_ungate,
   // sideband
   dcs_sb_if.master         sb
);
   logic [SB_AW-1:0] addr_r;
   logic [31:0]      data_r;
   logic             busy_r;
   logic             wr_r;
   logic             err_r;
   logic             ungate_r;
   logic             rd_ready_r;
   logic [31:0]      prdata_r;
   logic             slverr_r;
   logic             acc;
   logic             wr_acc;

   assign acc    = psel & penable & rd_ready_r;
   assign wr_acc = acc & pwrite;

   // -----------------------------------------------------------------
   // apb: no wait states, writes land at the completing access edge
   // -----------------------------------------------------------------
   // access phase ready register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ready_r <= 1'b0;
      end else begin
         rd_ready_r <= psel & ~penable;
      end
   end

   // read mux and error answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
         slverr_r <= 1'b0;
      end else begin
         // answer stands for the access cycle only
         prdata_r <= 32'h0;
         slverr_r <= 1'b0;
         if (psel & ~penable) begin
            unique case (paddr)
               APB_SB_ADDR: begin
                  if (!pwrite) prdata_r <= {16'h0, addr_r};
               end
               APB_SB_DATA: begin
                  if (!pwrite) prdata_r <= data_r;
               end
               APB_SB_CTLSTAT: begin
                  if (!pwrite) prdata_r <= {29'h0, err_r, wr_r, busy_r};
               end
               APB_PIX_GATE: begin
                  if (!pwrite) prdata_r <= {31'h0, ungate_r};
               end
               default: slverr_r <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r <= '0;
      end else if (wr_acc && paddr == APB_SB_ADDR && !busy_r) begin
         addr_r <= pwdata[SB_AW-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_r <= 32'h0;
      end else if (sb.ack && !wr_r) begin
         data_r <= sb.rdata;
      end else if (wr_acc && paddr == APB_SB_DATA && !busy_r) begin
         data_r <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
         wr_r   <= 1'b0;
         err_r  <= 1'b0;
      end else if (busy_r) begin
         if (sb.ack) begin
            busy_r <= 1'b0;
            err_r  <= sb.err;
         end
      end else if (wr_acc && paddr == APB_SB_CTLSTAT && pwdata[BIT_CS_BUSY]) begin
         busy_r <= 1'b1;
         wr_r   <= pwdata[BIT_CS_WRITE];
         err_r  <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ungate_r <= 1'b0;
      end else if (wr_acc && paddr == APB_PIX_GATE) begin
         ungate_r <= pwdata[0];
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign prdata     = prdata_r;
   assign pready     = rd_ready_r;
   assign pslverr    = slverr_r;
   assign pix_ungate = ungate_r;
   assign sb.req     = busy_r;
   assign sb.op      = wr_r ? DCS_OP_WRITE : DCS_OP_READ;
   assign sb.addr    = addr_r;
   assign sb.wdata   = data_r;
endmodule
`default_nettype wire

// file: design/dcs_synth_regs.sv
/*
 synthesizer register block of the three display clock resources.
 assumes a sideband master on pclk holding req until ack.
*/
`timescale 1ns/100ps
`default_nettype none
module dcs_synth_regs
   import dcs_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // sideband
   dcs_sb_if.target         sb,
   // active settings, spread reference clock
   output logic [30:0]      sp_frac,
   output logic             sp_dither_en,
   output logic [6:0]       sp_phase,
   output logic [6:0]       sp_div,
   output logic             sp_bending,
   // active settings, pixel clock
   output logic [6:0]       px_phase,
   output logic [6:0]       px_div,
   output logic             px_halve,
   // per resource: 0 spread, 1 nonspread, 2 pixel
   output logic [2:0]       power_down,
   output logic [2:0]       patt_halt,
   output logic [2:0]       div_only
);
   // index 0 spread, 1 pixel for double-buffered fields
   logic [30:0] frac_stg_r;
   logic        dith_stg_r;
   logic [6:0]  phase_stg_r [2];
   logic [6:0]  div_stg_r   [2];
   logic [1:0]  prop_r;
   logic [30:0] frac_act_r;
   logic        dith_act_r;
   logic [6:0]  phase_act_r [2];
   logic [6:0]  div_act_r   [2];
   logic        halve_r;
   logic [2:0]  pdn_r;
   logic [2:0]  halt_r;
   logic [2:0]  donly_r;
   logic        ack_r;
   logic        err_r;
   logic [31:0] rdata_r;
   logic [7:0]  tgt;
   logic [7:0]  ofs;
   logic [1:0]  ci;        // clock index 0..2, 3 = none
   logic        hit;
   logic        wen;

   assign tgt = sb.addr[SB_AW-1:START_W];
   assign ofs = sb.addr[START_W-1:0];

   always_comb begin
      ci = 2'd3;
      unique case (tgt)
         TGT_SPREAD:    ci = 2'd0;
         TGT_NONSPREAD: ci = 2'd1;
         TGT_PIXEL:     ci = 2'd2;
         default:       ci = 2'd3;
      endcase
   end

   // register existence per target
   always_comb begin
      hit = 1'b0;
      if (ci != 2'd3) begin
         unique case (ofs)
            OFS_INT_PHASE_DIV: hit = (ci != 2'd1);
            OFS_FRAC_DITHER:   hit = (ci == 2'd0);
            OFS_MOD_CTRL:      hit = 1'b1;
            OFS_HALF_DIV:      hit = (ci == 2'd2);
            default:           hit = 1'b0;
         endcase
      end
   end

   assign wen = sb.req & ~ack_r & hit & (sb.op == DCS_OP_WRITE);

   // -----------------------------------------------------------------
   // sideband answer: one cycle after request
   // -----------------------------------------------------------------
   // ack once per request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_r   <= 1'b0;
         err_r   <= 1'b0;
         rdata_r <= 32'h0;
      end else begin
         ack_r   <= sb.req & ~ack_r;
         err_r   <= sb.req & ~ack_r & ~hit;
         rdata_r <= 32'h0;
         if (sb.req && !ack_r && hit) begin
            unique case (ofs)
               OFS_INT_PHASE_DIV: rdata_r <= {17'h0, phase_stg_r[ci[1]],
                                              div_stg_r[ci[1]], prop_r[ci[1]]};
               OFS_FRAC_DITHER:   rdata_r <= {frac_stg_r, dith_stg_r};
               OFS_MOD_CTRL:      rdata_r <= {23'h0, donly_r[ci], 4'h0,
                                              halt_r[ci], 2'b00, pdn_r[ci]};
               default:           rdata_r <= {27'h0, halve_r, 4'h0};
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frac_stg_r <= FRAC_RESET;
         dith_stg_r <= 1'b0;
      end else if (wen && ofs == OFS_FRAC_DITHER) begin
         frac_stg_r <= sb.wdata[FRAC_LSB +: FRAC_W];
         dith_stg_r <= sb.wdata[BIT_DITHER_EN];
      end
   end

   // per double-buffered resource: spread (0) and pixel (1)
   for (genvar g = 0; g < 2; g++) begin : g_dbuf
      logic wsel;
      assign wsel = wen && ofs == OFS_INT_PHASE_DIV && ci[1] == 1'(g);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            phase_stg_r[g] <= PHASE_RESET;
            div_stg_r[g]   <= DIV_RESET;
         end else if (wsel) begin
            phase_stg_r[g] <= sb.wdata[PHASE_LSB +: PHASE_W];
            // reserved divider codes are held at the minimum
            div_stg_r[g]   <= (sb.wdata[DIV_LSB +: DIV_W] < DIV_MIN_CODE) ?
                              DIV_MIN_CODE : sb.wdata[DIV_LSB +: DIV_W];
         end
      end
      // pending set by write, cleared after apply
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            prop_r[g] <= 1'b0;
         end else if (wsel && sb.wdata[BIT_PROPAGATE]) begin
            prop_r[g] <= 1'b1;
         end else begin
            prop_r[g] <= 1'b0;
         end
      end
      // active copy changes only on propagate
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            phase_act_r[g] <= PHASE_RESET;
            div_act_r[g]   <= DIV_RESET;
         end else if (prop_r[g]) begin
            phase_act_r[g] <= phase_stg_r[g];
            div_act_r[g]   <= div_stg_r[g];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frac_act_r <= FRAC_RESET;
         dith_act_r <= 1'b0;
      end else if (prop_r[0]) begin
         frac_act_r <= frac_stg_r;
         dith_act_r <= dith_stg_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halve_r <= 1'b0;
      end else if (wen && ofs == OFS_HALF_DIV) begin
         halve_r <= sb.wdata[BIT_HALVE];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdn_r   <= PDN_RESET;
         halt_r  <= 3'b000;
         donly_r <= 3'b000;
      end else if (wen && ofs == OFS_MOD_CTRL) begin
         pdn_r[ci]   <= sb.wdata[BIT_POWER_DN_N];
         halt_r[ci]  <= sb.wdata[BIT_PATT_HALT];
         donly_r[ci] <= sb.wdata[BIT_DIV_ONLY];
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign sb.ack       = ack_r;
   assign sb.err       = err_r;
   assign sb.rdata     = rdata_r;
   assign sp_frac      = frac_act_r;
   assign sp_dither_en = dith_act_r;
   assign sp_phase     = phase_act_r[0];
   assign sp_div       = div_act_r[0];
   // bent when any active phase step or dither enabled
   assign sp_bending   = (phase_act_r[0] != PHASE_RESET) | dith_act_r;
   // pixel frequency from divider, phase, halve
   assign px_phase     = phase_act_r[1];
   assign px_div       = div_act_r[1];
   assign px_halve     = halve_r;
   assign power_down   = pdn_r;
   assign patt_halt    = halt_r;
   assign div_only     = donly_r;
endmodule
`default_nettype wire

// file: sim/dcs_checker.sv
/*
 sideband handshake checker for the display clock synthesizer link.
 assumes it sits beside the dcs_sb_if instance that joins both ends.
*/
`timescale 1ns/100ps
`default_nettype none
module dcs_checker
   import dcs_pkg::*;
(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // sideband signals
   input  wire logic             req,
   input  wire dcs_op_t          op,
   input  wire logic [SB_AW-1:0] addr,
   input  wire logic [31:0]      wdata,
   input  wire logic             ack,
   input  wire logic [31:0]      rdata,
   input  wire logic             err
);
   // -----------------------------------------------------------------
   // address decode of the documented targets and registers
   // -----------------------------------------------------------------
   logic tgt_known;
   logic reg_known;
   logic [7:0] tg;
   logic [7:0] st;
   assign tg = addr[15:8];
   assign st = addr[7:0];
   assign tgt_known = tg inside {TGT_SPREAD, TGT_NONSPREAD, TGT_PIXEL};
   assign reg_known = (tg == TGT_SPREAD && st inside {8'h00, 8'h04, 8'h0c})
                   || (tg == TGT_NONSPREAD && st == 8'h0c)
                   || (tg == TGT_PIXEL && st inside {8'h00, 8'h0c, 8'h10});
   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // launch then answer then release
   sequence s_launch;
      !req ##1 req;
   endsequence
   sequence s_answer;
      ack ##1 !req;
   endsequence
   a_launch_answer: assert property (s_launch |=> s_answer)
      else $error("sideband launch not answered in one cycle");
   a_ack_pulse: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_ack_has_req: assert property (ack |-> req)
      else $error("ack without request");
   a_wait_bounded: assert property (req |-> ##[0:2] ack)
      else $error("request waits too long");
   a_req_steady: assert property (req && !ack |=> req && $stable(addr) && $stable(op)
                                  && $stable(wdata))
      else $error("request changed before ack");
   a_known_ok: assert property (ack && reg_known |-> !err)
      else $error("known register refused");
   a_unknown_tgt: assert property (ack && !tgt_known |-> err)
      else $error("unknown target accepted");
   a_unknown_reg: assert property (ack && tgt_known && !reg_known |-> err)
      else $error("unknown register accepted");
endmodule
`default_nettype wire

// file: sim/test_display_clock_synth_ctrl.sv
/*
 testbench joining the apb sideband master and the synthesizer registers.
 assumes the designs and dcs_sb_if compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module test_display_clock_synth_ctrl;
   import dcs_pkg::*;
   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, v, f;
   logic pready, pslverr, pix_ungate, e, sp_dither_en, sp_bending, px_halve;
   logic [30:0] sp_frac;
   logic [6:0] sp_phase, sp_div, px_phase, px_div, d, p, gd, gp;
   logic [2:0] power_down, patt_halt, div_only;
   logic [6:0] ad [2];
   logic [7:0] t;
   logic [7:0] tg [3] = '{TGT_SPREAD, TGT_NONSPREAD, TGT_PIXEL};
   logic [31:0] lfsr = 32'h3e;
   int errors = 0, compares = 0;
   // clock, 10 ns period
   always #5 pclk = ~pclk;
   // -----------------------------------------------------------------
   // design ends, link and checker
   // -----------------------------------------------------------------
   dcs_sb_if sb_if();
   dcs_sb_master dcs_sb_master_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_ungate(pix_ungate),
      .sb(sb_if));
   dcs_synth_regs dcs_synth_regs_i (.pclk(pclk), .presetn(presetn), .sb(sb_if),
      .sp_frac(sp_frac), .sp_dither_en(sp_dither_en), .sp_phase(sp_phase),
      .sp_div(sp_div), .sp_bending(sp_bending), .px_phase(px_phase), .px_div(px_div),
      .px_halve(px_halve), .power_down(power_down), .patt_halt(patt_halt),
      .div_only(div_only));
   dcs_checker dcs_checker_i (.pclk(pclk), .presetn(presetn), .req(sb_if.req),
      .op(sb_if.op), .addr(sb_if.addr), .wdata(sb_if.wdata), .ack(sb_if.ack),
      .rdata(sb_if.rdata), .err(sb_if.err));
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // next pseudo-random word
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // verdict and end of run
   task automatic results();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic se);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk(32'(n), 1);
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
      #1;
   endtask
   // sideband order: address, write data, launch, poll, then read data
   task automatic sb(input logic [7:0] tt, input logic [7:0] o, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd, output logic er);
      logic [31:0] s;
      logic x;
      int n;
      apb(1, APB_SB_ADDR, {16'h0, tt, o}, s, x);
      if (w) apb(1, APB_SB_DATA, wd, s, x);
      apb(1, APB_SB_CTLSTAT, {30'h0, w, 1'b1}, s, x);
      #1;
      chk({16'h0, sb_if.addr}, {16'h0, tt, o});
      n = 0;
      do begin
         apb(0, APB_SB_CTLSTAT, 0, s, x);
         n++;
      end while (s[BIT_CS_BUSY] !== 1'b0 && n < 20);
      chk(32'(n < 20), 1);
      er = s[BIT_CS_ERR];
      rd = 0;
      if (!w) apb(0, APB_SB_DATA, 0, rd, x);
   endtask
   // -----------------------------------------------------------------
   // watchdog
   // -----------------------------------------------------------------
   initial begin
      repeat (3 * NEUTRAL_CYCLES + WARMUP_CYCLES + 20000) @(posedge pclk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      results();
   end
   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      // reset values
      chk({sp_div, px_div}, {DIV_RESET, DIV_RESET});
      chk({29'h0, power_down}, 32'(PDN_RESET));
      chk({sp_frac, sp_dither_en, px_halve}, 0);
      chk({sp_phase, px_phase, patt_halt, div_only, pix_ungate}, 0);
      sb(TGT_SPREAD, OFS_INT_PHASE_DIV, 0, 0, v, e);
      chk(v, 32'({DIV_RESET, 1'b0}));
      sb(TGT_SPREAD, OFS_FRAC_DITHER, 0, 0, v, e);
      chk(v, 0);
      for (int i = 0; i < 3; i++) begin
         sb(tg[i], OFS_MOD_CTRL, 0, 0, v, e);
         chk(v, 32'(PDN_RESET[i]));
      end
      $display("test reset done");
      // staged then propagated settings, corners then random
      ad[0] = DIV_RESET;
      ad[1] = DIV_RESET;
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 4; i++) begin
            t = k ? TGT_PIXEL : TGT_SPREAD;
            v = rnd();
            d = (i == 0) ? 7'h7f : (i == 1) ? 7'h03 : 7'(3 + v % 125);
            p = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : v[14:8];
            f = rnd();
            if (k == 0) sb(t, OFS_FRAC_DITHER, 1, f, v, e);
            sb(t, OFS_INT_PHASE_DIV, 1, {17'h0, p, d, 1'b0}, v, e);
            sb(t, OFS_INT_PHASE_DIV, 0, 0, v, e);
            chk(v, {17'h0, p, d, 1'b0});
            gd = k ? px_div : sp_div;
            chk(32'(gd), 32'(ad[k]));
            sb(t, OFS_INT_PHASE_DIV, 1, {17'h0, p, d, 1'b1}, v, e);
            sb(t, OFS_INT_PHASE_DIV, 0, 0, v, e);
            chk(v, {17'h0, p, d, 1'b0});
            ad[k] = d;
            gd = k ? px_div : sp_div;
            gp = k ? px_phase : sp_phase;
            chk(32'(gd), 32'(d));
            chk(32'(gp), 32'(p));
            if (k == 0) begin
               chk({sp_frac, sp_dither_en}, f);
               chk(32'(sp_bending), 32'(p != 0 || f[0]));
            end
         end
      end
      sb(TGT_PIXEL, OFS_INT_PHASE_DIV, 1, 32'h3, v, e);
      chk(32'(px_div), 32'(DIV_MIN_CODE));
      $display("test propagate done");
      // power, halt and divide-only per resource
      for (int i = 0; i < 3; i++) begin
         sb(tg[i], OFS_MOD_CTRL, 1, 32'h8, v, e);
         chk({power_down[i], patt_halt[i], e}, 3'b010);
         repeat (NEUTRAL_CYCLES) @(posedge pclk);
         sb(tg[i], OFS_MOD_CTRL, 1, 32'h101, v, e);
         chk({power_down[i], patt_halt[i], div_only[i]}, 3'b101);
         sb(tg[i], OFS_MOD_CTRL, 0, 0, v, e);
         chk(v, 32'h101);
      end
      sb(TGT_PIXEL, OFS_HALF_DIV, 1, 32'h10, v, e);
      chk(32'(px_halve), 1);
      $display("test control done");
      // refusals and pixel gate
      sb(8'h07, OFS_MOD_CTRL, 0, 0, v, e);
      chk(32'(e), 1);
      sb(TGT_NONSPREAD, OFS_FRAC_DITHER, 1, 32'h1, v, e);
      chk(32'(e), 1);
      apb(0, 8'h40, 0, v, e);
      chk(32'(e), 1);
      // power on, warm up, then ungate
      sb(TGT_PIXEL, OFS_MOD_CTRL, 1, 0, v, e);
      chk(32'(power_down[2]), 0);
      chk(32'(pix_ungate), 0);
      repeat (WARMUP_CYCLES) @(posedge pclk);
      apb(1, APB_PIX_GATE, 1, v, e);
      chk(32'(pix_ungate), 1);
      apb(0, APB_PIX_GATE, 0, v, e);
      chk(v, 1);
      $display("test refusal done");
      results();
   end
endmodule
`default_nettype wire
